// *** logic/rpsc_pkg.sv ***
/*
 * Shared constants and types for the retimer strap and mode control block.
 * Assumes three-level straps reach the core already resolved into a two-bit code.
 */
`default_nettype none

package rpsc_pkg;

    // Resolved three-level strap code
    typedef enum logic [1:0] {
        RPSC_LVL_LOW,
        RPSC_LVL_MID,
        RPSC_LVL_HIGH,
        RPSC_LVL_BAD
    } rpsc_level_t;

    // De-emphasis choices
    localparam logic [1:0] DEEMPH_0DB = 2'h0;
    localparam logic [1:0] DEEMPH_M2DB = 2'h1;

    // Equalizer choices
    localparam logic [1:0] EQ_FIXED_LOW = 2'h0;
    localparam logic [1:0] EQ_ADAPTIVE = 2'h1;
    localparam logic [1:0] EQ_FIXED_HIGH = 2'h2;

    // Transmit termination choices
    localparam logic [1:0] TERM_AUTO = 2'h0;
    localparam logic [1:0] TERM_OFF = 2'h1;
    localparam logic [1:0] TERM_DIFF = 2'h2;

    // Lane swap choices
    localparam logic [1:0] LANE_NORMAL = 2'h0;
    localparam logic [1:0] LANE_ORDER_SWAP = 2'h1;
    localparam logic [1:0] LANE_POL_SWAP = 2'h2;

    // Data-rate band from the rate detector
    localparam logic [1:0] RATE_BELOW_2G = 2'h0;
    localparam logic [1:0] RATE_2G_TO_3G4 = 2'h1;
    localparam logic [1:0] RATE_ABOVE_3G4 = 2'h2;

    // Reset values
    localparam logic [1:0] DEEMPH_RST = 2'h0;
    localparam logic [1:0] EQ_RST = 2'h1;
    localparam logic [1:0] TERM_RST = 2'h0;
    localparam logic [1:0] LANE_RST = 2'h0;
    localparam logic [2:0] ADDR_RST = 3'h0;

    // Width of the I2C slave address bits this block supplies
    localparam int ADDR_BITS = 3;

    // Cycles the block holds its internal reset after operation enable falls
    localparam int RESET_HOLD_CYCLES = 2;

endpackage

`default_nettype wire

// *** logic/rpsc_core.sv ***
/*
 * Strap decoding and control-mode logic of a serial video link retimer.
 * Assumes every input is synchronous to clk. Each strap comes in already resolved to
 * a low, mid or high code. The datapath consumes the decoded settings.
 */
`default_nettype none

// What this block does
// R1: Power down while operation enable is low, except during the reset pulse
// R2: Falling operation enable resets the device
// R3: Detect off: termination stays connected unless powered down
// R4: Detect on: standby without valid clock
// R5: De-emphasis strap: low -2dB, open 0dB
// R6: I2C mode: de-emphasis from I2C setting
// R7: Equalizer strap: 7.5dB, adaptive, 14dB
// R8: I2C mode: equalizer pin is address bit1
// R9: Mode select high I2C, low strap
// R10: Strap mode ignores I2C writes to straps
// R11: High address input gives address bit2
// R12: Termination strap: high off, open auto
// R13: Auto termination only from 2 to 3.4G
// R14: Swap strap: high polarity in retimer mode, low order
// R15: Board uses 65k resistors or leaves open
// R16: Straps latched at reset or power-up exit
module rpsc_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic operation_enable,
    input wire logic signal_detect_enable,
    input wire logic input_clock_valid,
    input wire logic control_mode_select,
    input wire logic [1:0] deemphasis_strap,
    input wire logic [1:0] equalizer_strap_addr_bit1,
    input wire logic high_address_select,
    input wire logic [1:0] transmit_termination_strap,
    input wire logic [1:0] lane_swap_polarity_strap,
    input wire logic i2c_cfg_write,
    input wire logic [1:0] i2c_deemphasis,
    input wire logic [1:0] i2c_equalizer,
    input wire logic [1:0] i2c_termination,
    input wire logic [1:0] i2c_lane_mode,
    input wire logic [1:0] rate_band,
    input wire logic retimer_mode,
    output logic power_down,
    output logic device_reset,
    output logic standby,
    output logic signal_detect_active,
    output logic rx_termination_on,
    output logic i2c_mode,
    output logic [2:0] i2c_slave_addr,
    output logic [1:0] deemphasis_sel,
    output logic [1:0] equalizer_sel,
    output logic [1:0] tx_termination_sel,
    output logic [1:0] lane_mode_sel,
    output logic strap_reserved_err
);

    localparam logic [1:0] HOLD_MAX = 2'(rpsc_pkg::RESET_HOLD_CYCLES);

    // The hold counter is two bits wide, so longer holds would wrap early
    if (rpsc_pkg::RESET_HOLD_CYCLES < 1 || rpsc_pkg::RESET_HOLD_CYCLES > 3) begin : g_hold_check
        $error("Reset hold count does not fit the hold counter");
    end

    typedef enum logic [1:0] {
        RPSC_ST_OFF,
        RPSC_ST_RESET,
        RPSC_ST_SAMPLE,
        RPSC_ST_RUN
    } rpsc_state_t;

    rpsc_state_t state_q, state_d;
    logic oe_prev_q, oe_prev_d;
    logic [1:0] hold_q, hold_d;
    logic mode_q, mode_d;
    logic [1:0] deemph_q, deemph_d;
    logic [1:0] eq_q, eq_d;
    logic [1:0] term_cfg_q, term_cfg_d;
    logic [1:0] term_q, term_d;
    logic [1:0] lane_q, lane_d;
    logic [2:0] addr_q, addr_d;
    logic pd_q, pd_d;
    logic rst_q, rst_d;
    logic stby_q, stby_d;
    logic det_q, det_d;
    logic rxterm_q, rxterm_d;
    logic err_q, err_d;
    logic [1:0] lane_eff;
    logic [1:0] lane_d_out;
    logic [1:0] lane_out_q;

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        oe_prev_d = operation_enable;
        mode_d = mode_q;
        deemph_d = deemph_q;
        eq_d = eq_q;
        term_cfg_d = term_cfg_q;
        lane_d = lane_q;
        addr_d = addr_q;
        err_d = err_q;
        case (state_q)
            RPSC_ST_OFF: begin
                if (operation_enable) begin
                    state_d = RPSC_ST_SAMPLE; // [R1]
                end
            end
            RPSC_ST_RESET: begin
                // Reset pulse is held a few cycles so the datapath sees it reliably
                if (hold_q == HOLD_MAX - 2'h1) begin
                    hold_d = 2'h0;
                    state_d = operation_enable ? RPSC_ST_SAMPLE : RPSC_ST_OFF;
                end else begin
                    hold_d = hold_q + 2'h1;
                end
            end
            RPSC_ST_SAMPLE: begin
                // Straps captured once, so later board noise cannot retune the link
                mode_d = control_mode_select; // [R9] [R16]
                addr_d[2] = high_address_select; // [R11]
                addr_d[0] = 1'b0;
                err_d = 1'b0;
                if (control_mode_select) begin
                    // Two-level use of the equalizer pin: only the high code counts
                    addr_d[1] = (equalizer_strap_addr_bit1 == rpsc_pkg::RPSC_LVL_HIGH); // [R8]
                    deemph_d = i2c_deemphasis; // [R6]
                    eq_d = i2c_equalizer;
                    term_cfg_d = i2c_termination;
                    lane_d = i2c_lane_mode;
                end else begin
                    addr_d[1] = 1'b0;
                    case (deemphasis_strap) // [R5]
                        rpsc_pkg::RPSC_LVL_LOW: deemph_d = rpsc_pkg::DEEMPH_M2DB;
                        rpsc_pkg::RPSC_LVL_MID: deemph_d = rpsc_pkg::DEEMPH_0DB;
                        default: begin
                            deemph_d = rpsc_pkg::DEEMPH_0DB;
                            err_d = 1'b1;
                        end
                    endcase
                    case (equalizer_strap_addr_bit1) // [R7]
                        rpsc_pkg::RPSC_LVL_LOW: eq_d = rpsc_pkg::EQ_FIXED_LOW;
                        rpsc_pkg::RPSC_LVL_HIGH: eq_d = rpsc_pkg::EQ_FIXED_HIGH;
                        default: eq_d = rpsc_pkg::EQ_ADAPTIVE;
                    endcase
                    case (transmit_termination_strap) // [R12]
                        rpsc_pkg::RPSC_LVL_HIGH: term_cfg_d = rpsc_pkg::TERM_OFF;
                        rpsc_pkg::RPSC_LVL_LOW: begin
                            term_cfg_d = rpsc_pkg::TERM_AUTO;
                            err_d = 1'b1;
                        end
                        default: term_cfg_d = rpsc_pkg::TERM_AUTO;
                    endcase
                    case (lane_swap_polarity_strap) // [R14]
                        rpsc_pkg::RPSC_LVL_HIGH: lane_d = rpsc_pkg::LANE_POL_SWAP;
                        rpsc_pkg::RPSC_LVL_LOW: lane_d = rpsc_pkg::LANE_ORDER_SWAP;
                        default: lane_d = rpsc_pkg::LANE_NORMAL;
                    endcase
                end
                state_d = RPSC_ST_RUN;
            end
            RPSC_ST_RUN: begin
                // I2C updates only reach the settings in I2C mode
                if (mode_q && i2c_cfg_write) begin // [R10]
                    deemph_d = i2c_deemphasis; // [R6]
                    eq_d = i2c_equalizer;
                    term_cfg_d = i2c_termination;
                    lane_d = i2c_lane_mode;
                end
            end
            default: state_d = RPSC_ST_OFF;
        endcase
        if (oe_prev_q && !operation_enable) begin
            state_d = RPSC_ST_RESET; // [R2]
            hold_d = 2'h0;
            mode_d = 1'b0;
            deemph_d = rpsc_pkg::DEEMPH_RST;
            eq_d = rpsc_pkg::EQ_RST;
            term_cfg_d = rpsc_pkg::TERM_RST;
            lane_d = rpsc_pkg::LANE_RST;
            addr_d = rpsc_pkg::ADDR_RST;
        end
    end

    always_comb begin
        // Polarity inversion is a retimer feature; redriver falls back to normal
        lane_eff = lane_q;
        if (lane_q == rpsc_pkg::LANE_POL_SWAP && !retimer_mode) begin
            lane_eff = rpsc_pkg::LANE_NORMAL; // [R14]
        end
        term_d = term_cfg_q;
        if (term_cfg_q == rpsc_pkg::TERM_AUTO) begin
            term_d = (rate_band == rpsc_pkg::RATE_2G_TO_3G4) ?
                     rpsc_pkg::TERM_DIFF : rpsc_pkg::TERM_AUTO; // [R13]
        end
        lane_d_out = lane_eff;
        pd_d = (state_d == RPSC_ST_OFF); // [R1]
        rst_d = (state_d == RPSC_ST_RESET); // [R2]
        det_d = signal_detect_enable && (state_d == RPSC_ST_RUN); // [R3] [R4]
        stby_d = det_d && !input_clock_valid; // [R4]
        rxterm_d = !pd_d && !stby_d; // [R3]
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= RPSC_ST_OFF;
            hold_q <= 2'h0;
            oe_prev_q <= 1'b0;
            mode_q <= 1'b0;
            deemph_q <= rpsc_pkg::DEEMPH_RST;
            eq_q <= rpsc_pkg::EQ_RST;
            term_cfg_q <= rpsc_pkg::TERM_RST;
            term_q <= rpsc_pkg::TERM_RST;
            lane_q <= rpsc_pkg::LANE_RST;
            lane_out_q <= rpsc_pkg::LANE_RST;
            addr_q <= rpsc_pkg::ADDR_RST;
            err_q <= 1'b0;
            pd_q <= 1'b1;
            rst_q <= 1'b0;
            det_q <= 1'b0;
            stby_q <= 1'b0;
            rxterm_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            oe_prev_q <= oe_prev_d;
            mode_q <= mode_d;
            deemph_q <= deemph_d;
            eq_q <= eq_d;
            term_cfg_q <= term_cfg_d;
            term_q <= term_d;
            lane_q <= lane_d;
            lane_out_q <= lane_d_out;
            addr_q <= addr_d;
            err_q <= err_d;
            pd_q <= pd_d;
            rst_q <= rst_d;
            det_q <= det_d;
            stby_q <= stby_d;
            rxterm_q <= rxterm_d;
        end
    end

    assign power_down = pd_q;
    assign device_reset = rst_q;
    assign standby = stby_q;
    assign signal_detect_active = det_q;
    assign rx_termination_on = rxterm_q;
    assign i2c_mode = mode_q;
    assign i2c_slave_addr = addr_q;
    assign deemphasis_sel = deemph_q;
    assign equalizer_sel = eq_q;
    assign tx_termination_sel = term_q;
    assign lane_mode_sel = lane_out_q;
    assign strap_reserved_err = err_q;

endmodule

`default_nettype wire

// *** tb/rpsc_core_properties.sv ***
/* Timing checks on the strap and mode control block.
   Assumes one clock and the bench holding settings inputs between writes. */
`default_nettype none
module rpsc_core_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic operation_enable,
    input wire logic signal_detect_enable,
    input wire logic input_clock_valid,
    input wire logic i2c_cfg_write,
    input wire logic [1:0] i2c_deemphasis,
    input wire logic power_down,
    input wire logic device_reset,
    input wire logic standby,
    input wire logic rx_termination_on,
    input wire logic i2c_mode,
    input wire logic [1:0] deemphasis_sel,
    input wire logic [1:0] equalizer_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_fall_resets: assert property ($fell(operation_enable) |-> ##1 device_reset[*2])
        else $error("no reset pulse after enable fell");
    a_off_powers_down: assert property (!operation_enable[*5]
        |-> power_down && !rx_termination_on)
        else $error("not powered down");
    a_on_runs: assert property (operation_enable[*4] |-> !power_down)
        else $error("still powered down");
    a_detect_off_term: assert property ((operation_enable && !signal_detect_enable)[*5]
        |-> rx_termination_on && !standby)
        else $error("termination dropped with detector off");
    a_no_clock_standby: assert property ((operation_enable && signal_detect_enable
        && !input_clock_valid)[*5] |-> standby && !rx_termination_on)
        else $error("no standby without clock");
    a_clock_no_standby: assert property ((operation_enable && signal_detect_enable
        && input_clock_valid)[*5] |-> !standby)
        else $error("standby with valid clock");
    a_strap_holds: assert property ((operation_enable && !i2c_mode)[*6]
        |-> $stable(deemphasis_sel) && $stable(equalizer_sel))
        else $error("strap setting changed while running");
    a_i2c_load: assert property (i2c_mode && i2c_cfg_write
        |-> ##[1:2] deemphasis_sel == i2c_deemphasis)
        else $error("written de-emphasis not applied");
endmodule
bind rpsc_core rpsc_core_chk i_chk (.clk, .nrst, .operation_enable, .signal_detect_enable,
    .input_clock_valid, .i2c_cfg_write, .i2c_deemphasis, .power_down, .device_reset,
    .standby, .rx_termination_on, .i2c_mode, .deemphasis_sel, .equalizer_sel);
`default_nettype wire

// *** tb/rpsc_board.sv ***
/* Board model: strap resistors and mode pins.
   Assumes straps reach the core already resolved to level codes. */
`default_nettype none
module rpsc_board (
    input wire logic [7:0] lvl,
    input wire logic cms,
    input wire logic addr_hi,
    output logic [1:0] de,
    output logic [1:0] eq,
    output logic [1:0] term,
    output logic [1:0] swap,
    output logic control_mode_select,
    output logic high_address_select
);
    timeunit 1ns;
    timeprecision 1ns;
    // Resistor to ground, open, or resistor to supply per strap
    assign {de, eq, term, swap} = lvl;
    assign control_mode_select = cms;
    // Left open in strap mode, so the pull-down reads low
    assign high_address_select = cms & addr_hi;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench for the strap and mode control block.
   Assumes the board model drives all strap pins. */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, oe, sde, icv, wr, rm, cms, ah, drst, pd, sb, rxt, im, err;
    logic [1:0] wde, rb, ds, es, ts, ls, de, eq, tm, sw;
    logic [2:0] adr;
    logic [7:0] lvl;
    logic cmsel, hsel, sdact;
    int error_cnt = 0, checks = 0, cyc = 0;
    logic [1:0] de_x[3] = '{2'h1, 2'h0, 2'h0};
    logic [1:0] eq_x[3] = '{2'h0, 2'h1, 2'h2};
    logic [1:0] te_x[3] = '{2'h2, 2'h2, 2'h1};
    logic [1:0] ln_x[3] = '{2'h1, 2'h0, 2'h2};
    rpsc_board i_rpsc_board (.lvl(lvl), .cms(cms), .addr_hi(ah), .de(de), .eq(eq), .term(tm),
        .swap(sw), .control_mode_select(cmsel), .high_address_select(hsel));
    rpsc_core i_rpsc_core (.clk(clk), .nrst(nrst), .operation_enable(oe),
        .signal_detect_enable(sde), .input_clock_valid(icv), .control_mode_select(cmsel),
        .deemphasis_strap(de), .equalizer_strap_addr_bit1(eq), .high_address_select(hsel),
        .transmit_termination_strap(tm), .lane_swap_polarity_strap(sw), .i2c_cfg_write(wr),
        .i2c_deemphasis(wde), .i2c_equalizer(wde), .i2c_termination(wde),
        .i2c_lane_mode(wde), .rate_band(rb), .retimer_mode(rm), .power_down(pd),
        .device_reset(drst), .standby(sb), .signal_detect_active(sdact), .rx_termination_on(rxt),
        .i2c_mode(im), .i2c_slave_addr(adr), .deemphasis_sel(ds), .equalizer_sel(es),
        .tx_termination_sel(ts), .lane_mode_sel(ls), .strap_reserved_err(err));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [2:0] x, input logic [2:0] g);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Power cycle so the straps are sampled afresh
    task automatic boot(input logic [7:0] l, input logic c, input logic a);
        @(posedge clk);
        oe <= 0;
        lvl <= l;
        cms <= c;
        ah <= a;
        wt(6);
        @(posedge clk);
        oe <= 1;
        wt(6);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        nrst = 0;
        oe = 1;
        sde = 0;
        icv = 1;
        wr = 0;
        wde = 2'h1;
        rb = 2'h1;
        rm = 1;
        lvl = 8'h55;
        cms = 0;
        ah = 0;
        repeat (8) @(posedge clk);
        nrst <= 1;
        for (int l = 0; l < 3; l++) begin
            boot(8'(l) * 8'h55, 1'b0, 1'b0);
            chk("deemph", de_x[l], ds);
            chk("eq", eq_x[l], es);
            chk("term", te_x[l], ts);
            chk("lane", ln_x[l], ls);
            chk("reserved", 3'(l != 1), err);
            chk("mode", 3'h0, im);
            @(posedge clk);
            lvl <= ~lvl;
            wr <= 1;
            wde <= 2'h2;
            @(posedge clk);
            wr <= 0;
            wt(4);
            chk("held deemph", de_x[l], ds);
            chk("held eq", eq_x[l], es);
        end
        @(posedge clk);
        rb <= 2'h0;
        rm <= 0;
        wde <= 2'h1;
        boot(8'h56, 1'b0, 1'b0);
        chk("term slow", 3'h0, ts);
        chk("lane redriver", 3'h0, ls);
        @(posedge clk);
        rb <= 2'h1;
        rm <= 1;
        boot(8'h65, 1'b1, 1'b1);
        chk("mode", 3'h1, im);
        chk("addr", 3'h6, adr);
        chk("boot deemph", 3'h1, ds);
        // A new value, so a write that is ignored cannot pass unnoticed
        @(posedge clk);
        wr <= 1;
        wde <= 2'h0;
        @(posedge clk);
        wr <= 0;
        wt(2);
        chk("i2c deemph", 3'h0, ds);
        boot(8'h45, 1'b1, 1'b0);
        chk("addr", 3'h0, adr);
        @(posedge clk);
        oe <= 0;
        wt(1);
        chk("reset", 3'h1, drst);
        wt(4);
        chk("pd", 3'h1, pd);
        chk("rx term", 3'h0, rxt);
        @(posedge clk);
        oe <= 1;
        sde <= 1;
        icv <= 0;
        wt(6);
        chk("pd", 3'h0, pd);
        chk("standby", 3'h1, sb);
        chk("rx term", 3'h0, rxt);
        chk("detect", 3'h1, sdact);
        @(posedge clk);
        icv <= 1;
        wt(4);
        chk("standby", 3'h0, sb);
        @(posedge clk);
        sde <= 0;
        icv <= 0;
        wt(4);
        chk("standby", 3'h0, sb);
        chk("rx term", 3'h1, rxt);
        chk("detect", 3'h0, sdact);
        conclude();
    end
endmodule
`default_nettype wire
